// ==== hdl/bus_arb_dev.sv ====
// processor end: acknowledge, suspend, host grant, ready drive, request lines
// assumes external wire resolution and pull-ups on unused request lines
`timescale 1ns/10ps
`default_nettype none
module bus_arb_dev
	import bus_arb_pkg::*;
#(
	parameter int WAIT_CYCLES = WAIT_CYCLES_DEF
)(
	input  wire logic                CORE_CLK_IN,
	input  wire logic                RST_N_IN,
	input  wire logic [ID_WIDTH-1:0] PROCESSOR_IDENTITY_INPUTS_IN,
	input  wire logic                READY_DRIVE_SELECT_IN,
	input  wire logic                EXT_ACCESS_REQ_IN,
	input  wire logic                SYNC_SLAVE_ACCESS_IN,
	input  wire logic                WANT_BUS_IN,
	output logic                     EXT_ACCESS_DONE_OUT,
	output logic                     IS_MASTER_OUT,
	bus_arb_if.dev                   link
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_DONE  = 3'b100
	} acc_state_t;

	acc_state_t state_reg;
	acc_state_t state_next;
	logic [2:0] hbr_sync_reg;
	logic [2:0] cs_sync_reg;
	logic [2:0] suspend_bus_float_sync_reg;
	logic       hbr_lvl_reg;
	logic       cs_lvl_reg;
	logic       suspend_bus_float_lvl_reg;
	logic       ack_keep_reg;
	logic       grant_reg;
	logic       master_reg;
	logic       float_reg;
	logic       ack_drv_reg;
	logic       rdy_low_reg;
	logic       rdy_oe_n_reg;
	logic       rdy_out_reg;
	logic       done_reg;
	logic [1:0] slave_wait_reg;
	logic [1:0] host_wait_reg;
	logic [5:0] br_oe_n_reg;
	logic [5:0] own_mask;
	logic       peer_req;
	logic       suspend_bus_float_asserted;

	function automatic logic [5:0] id_to_mask(input logic [ID_WIDTH-1:0] id);
		logic [5:0] m;
		m = 6'h00;
		if (id != ID_SINGLE && id <= 3'h6) begin
			m[id - 3'h1] = 1'b1;
		end
		return m;
	endfunction : id_to_mask

	assign own_mask      = id_to_mask(PROCESSOR_IDENTITY_INPUTS_IN);
	// peers with low request lines; own line excluded
	assign peer_req      = |(~link.br_in & ~own_mask);
	assign suspend_bus_float_asserted = suspend_bus_float_lvl_reg;

	assign link.ack_out              = 1'b0;
	assign link.ack_oe_n             = ~ack_drv_reg;
	assign link.host_bus_grant_out   = ~grant_reg;
	assign link.host_bus_grant_oe_n  = ~master_reg & ~grant_reg;
	assign link.host_wait_ready_out  = rdy_out_reg;
	assign link.host_wait_ready_oe_n = rdy_oe_n_reg;
	assign link.br_out               = 6'h00;
	assign link.br_oe_n              = br_oe_n_reg;
	assign link.bus_oe_n             = float_reg;
	assign EXT_ACCESS_DONE_OUT       = done_reg;
	assign IS_MASTER_OUT             = master_reg;

	// three-stage sync; level changes once stages two and three agree
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			hbr_sync_reg  <= 3'h7;
			cs_sync_reg   <= 3'h7;
			suspend_bus_float_sync_reg <= 3'h7;
			hbr_lvl_reg   <= 1'b0;
			cs_lvl_reg    <= 1'b0;
			suspend_bus_float_lvl_reg  <= 1'b0;
		end else begin
			hbr_sync_reg  <= {hbr_sync_reg[1:0], link.host_bus_request_n};
			cs_sync_reg   <= {cs_sync_reg[1:0], link.chip_select_n};
			suspend_bus_float_sync_reg <= {suspend_bus_float_sync_reg[1:0], link.suspend_bus_float_n};
			if (hbr_sync_reg[2] == hbr_sync_reg[1]) begin
				hbr_lvl_reg <= ~hbr_sync_reg[1];
			end
			if (cs_sync_reg[2] == cs_sync_reg[1]) begin
				cs_lvl_reg <= ~cs_sync_reg[1];
			end
			if (suspend_bus_float_sync_reg[2] == suspend_bus_float_sync_reg[1]) begin
				suspend_bus_float_lvl_reg <= ~suspend_bus_float_sync_reg[1];
			end
		end
	end

	// keeper: an undriven line reads as x/z in sim, so hold the last known level
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			ack_keep_reg <= 1'b1;
		end else if (link.ack_in === 1'b0 || link.ack_in === 1'b1) begin
			ack_keep_reg <= link.ack_in;
		end
	end

	// arbitration: host first, then peers, then own wish
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			grant_reg  <= 1'b0;
			master_reg <= 1'b0;
		end else begin
			if (hbr_lvl_reg && (master_reg || grant_reg)) begin
				grant_reg  <= 1'b1;
				master_reg <= 1'b0;
			end else if (!hbr_lvl_reg) begin
				grant_reg  <= 1'b0;
				master_reg <= WANT_BUS_IN & ~peer_req;
			end
		end
	end

	// float bus when suspended or not master
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			float_reg <= 1'b1;
		end else begin
			// a seen host request floats in the same edge that raises the grant
			float_reg <= suspend_bus_float_asserted | ~master_reg | grant_reg | hbr_lvl_reg;
		end
	end

	// own request line only, open-drain low while wanting the bus
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			br_oe_n_reg <= 6'h3F;
		end else begin
			br_oe_n_reg <= ~(own_mask & {6{WANT_BUS_IN}});
		end
	end

	// outbound access sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (EXT_ACCESS_REQ_IN && master_reg) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// stall on suspend or low acknowledge
				if (!suspend_bus_float_asserted && !float_reg && ack_keep_reg) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			state_reg <= ST_IDLE;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			done_reg  <= (state_next == ST_DONE);
		end
	end

	// inbound synchronous access: fixed wait count with acknowledge pulled low
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			slave_wait_reg <= 2'h0;
			ack_drv_reg    <= 1'b0;
		end else if (SYNC_SLAVE_ACCESS_IN && !master_reg) begin
			if (slave_wait_reg != WAIT_CYCLES[1:0]) begin
				slave_wait_reg <= slave_wait_reg + 2'h1;
				ack_drv_reg    <= 1'b1;
			end else begin
				ack_drv_reg    <= 1'b0;
			end
		end else begin
			slave_wait_reg <= 2'h0;
			ack_drv_reg    <= 1'b0;
		end
	end

	// host asynchronous access: ready low for the wait count, then high
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			host_wait_reg <= 2'h0;
			rdy_low_reg   <= 1'b0;
		end else if (cs_lvl_reg && hbr_lvl_reg) begin
			if (host_wait_reg != WAIT_CYCLES[1:0]) begin
				host_wait_reg <= host_wait_reg + 2'h1;
				rdy_low_reg   <= 1'b1;
			end else begin
				rdy_low_reg   <= 1'b0;
			end
		end else begin
			host_wait_reg <= 2'h0;
			rdy_low_reg   <= 1'b0;
		end
	end

	// open-drain only pulls low; active drive also drives high
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			rdy_oe_n_reg <= 1'b1;
			rdy_out_reg  <= 1'b0;
		end else if (cs_lvl_reg && hbr_lvl_reg) begin
			rdy_out_reg  <= ~rdy_low_reg;
			rdy_oe_n_reg <= ~(rdy_low_reg | READY_DRIVE_SELECT_IN);
		end else begin
			rdy_out_reg  <= 1'b0;
			rdy_oe_n_reg <= 1'b1;
		end
	end
endmodule : bus_arb_dev
`default_nettype wire

// ==== hdl/bus_arb_pkg.sv ====
// constants shared by both ends of the external bus access link
// assumes a single 50 MHz core clock on both ends
package bus_arb_pkg;
	localparam int CLK_PERIOD_NS   = 20;
	localparam int NUM_BR_LINES    = 6;
	localparam int ID_WIDTH        = 3;
	localparam logic [2:0] ID_SINGLE = 3'h0;
	localparam int SYNC_STAGES     = 3;
	localparam int WAIT_CYCLES_DEF = 2;
	localparam logic RDY_DRV_RESET = 1'b0;
	// host ignores ready this long after select: covers both sync paths and the wait
	localparam int READY_SETTLE_CYCLES = 10;
endpackage : bus_arb_pkg

// ==== hdl/bus_arb_if.sv ====
// interface joining the processor end and the host end
// assumes the testbench resolves open-drain and three-state wires from the enables
`timescale 1ns/10ps
`default_nettype none
interface bus_arb_if;
	logic       ack_out;
	logic       ack_oe_n;
	logic       ack_in;
	logic       suspend_bus_float_n;
	logic       host_bus_request_n;
	logic       host_bus_grant_out;
	logic       host_bus_grant_oe_n;
	logic       host_bus_grant_in;
	logic       chip_select_n;
	logic       host_wait_ready_out;
	logic       host_wait_ready_oe_n;
	logic       host_wait_ready_in;
	logic [5:0] br_out;
	logic [5:0] br_oe_n;
	logic [5:0] br_in;
	logic       bus_oe_n;
	modport dev (
		output ack_out, ack_oe_n, host_bus_grant_out, host_bus_grant_oe_n,
		output host_wait_ready_out, host_wait_ready_oe_n, br_out, br_oe_n, bus_oe_n,
		input  ack_in, suspend_bus_float_n, host_bus_request_n, host_bus_grant_in,
		input  chip_select_n, br_in
	);
	modport host (
		output suspend_bus_float_n, host_bus_request_n, chip_select_n,
		input  host_bus_grant_in, host_wait_ready_in
	);
endinterface : bus_arb_if
`default_nettype wire

// ==== hdl/bus_arb_host.sv ====
// host end: requests the bus, selects the processor, waits on ready
// assumes ready and grant arrive asynchronously from the processor end
`timescale 1ns/10ps
`default_nettype none
module bus_arb_host
	import bus_arb_pkg::*;
(
	input  wire logic CORE_CLK_IN,
	input  wire logic RST_N_IN,
	input  wire logic BUS_WANT_IN,
	input  wire logic ACCESS_REQ_IN,
	input  wire logic SUSPEND_REQ_IN,
	output logic      BUS_OWNED_OUT,
	output logic      ACCESS_DONE_OUT,
	bus_arb_if.host   link
);
	logic [2:0] grant_sync_reg;
	logic [2:0] rdy_sync_reg;
	logic       hbr_n_reg;
	logic       cs_n_reg;
	logic       suspend_bus_float_n_reg;
	logic       owned_reg;
	logic       done_reg;
	logic [3:0] settle_reg;
	logic       grant_lvl;
	logic       rdy_lvl;

	assign link.host_bus_request_n  = hbr_n_reg;
	assign link.chip_select_n       = cs_n_reg;
	assign link.suspend_bus_float_n = suspend_bus_float_n_reg;
	assign BUS_OWNED_OUT            = owned_reg;
	assign ACCESS_DONE_OUT          = done_reg;
	assign grant_lvl = (grant_sync_reg[2] == grant_sync_reg[1]) ? grant_sync_reg[1] : owned_reg;
	assign rdy_lvl   = (rdy_sync_reg[2] == rdy_sync_reg[1]) && rdy_sync_reg[1];

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			// idle levels of the pins, so no false grant or wait follows reset
			grant_sync_reg <= 3'h0;
			rdy_sync_reg   <= 3'h7;
		end else begin
			grant_sync_reg <= {grant_sync_reg[1:0], ~link.host_bus_grant_in};
			rdy_sync_reg   <= {rdy_sync_reg[1:0], link.host_wait_ready_in};
		end
	end

	// request held while access outstanding
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			hbr_n_reg <= 1'b1;
			owned_reg <= 1'b0;
		end else begin
			hbr_n_reg <= ~(BUS_WANT_IN | ACCESS_REQ_IN);
			owned_reg <= ~hbr_n_reg & grant_lvl;
		end
	end

	// chip select only while requesting the bus
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			cs_n_reg   <= 1'b1;
			done_reg   <= 1'b0;
			settle_reg <= 4'h0;
		end else begin
			cs_n_reg <= ~(ACCESS_REQ_IN & ~hbr_n_reg & owned_reg);
			// ready reads high before the far end has seen select, so wait it out
			if (cs_n_reg) begin
				settle_reg <= 4'h0;
			end else if (settle_reg != READY_SETTLE_CYCLES[3:0]) begin
				settle_reg <= settle_reg + 4'h1;
			end
			done_reg <= ~cs_n_reg & (settle_reg == READY_SETTLE_CYCLES[3:0]) & rdy_lvl & ~done_reg;
		end
	end

	// suspend only as deadlock recovery, driven by the user request
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			suspend_bus_float_n_reg <= 1'b1;
		end else begin
			suspend_bus_float_n_reg <= ~SUSPEND_REQ_IN;
		end
	end
endmodule : bus_arb_host
`default_nettype wire

// ==== tb/bus_arb_properties.sv ====
// checker on the link between the processor end and the host end
// assumes tb_top wires it to the link interface signals by name
`timescale 1ns/10ps
`default_nettype none
module bus_arb_properties (
	input wire logic       CORE_CLK_IN,
	input wire logic       RST_N_IN,
	input wire logic       ack_out,
	input wire logic       ack_oe_n,
	input wire logic       suspend_bus_float_n,
	input wire logic       host_bus_request_n,
	input wire logic       host_bus_grant_out,
	input wire logic       host_bus_grant_oe_n,
	input wire logic       host_bus_grant_in,
	input wire logic       chip_select_n,
	input wire logic       host_wait_ready_in,
	input wire logic       host_wait_ready_oe_n,
	input wire logic [5:0] br_oe_n,
	input wire logic       bus_oe_n
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// request must stay low a second cycle, so a glitch is not taken as a request
	sequence req_seen;
		$fell(host_bus_request_n) ##1 !host_bus_request_n;
	endsequence
	sequence grant_on;
		##[1:10] !host_bus_grant_in;
	endsequence
	a_ack_low_only: assert property (!ack_oe_n |-> !ack_out)
		else $error("ack driven high");
	a_grant_low_only: assert property (host_bus_request_n[*6] |->
		(host_bus_grant_oe_n || host_bus_grant_out)) else $error("grant held without request");
	a_ack_wait_bound: assert property (!ack_oe_n ##1 !ack_oe_n |=> ack_oe_n)
		else $error("ack wait too long");
	a_grant_answer: assert property (req_seen |-> grant_on)
		else $error("grant late");
	a_grant_hold_req: assert property (!host_bus_grant_in && !host_bus_request_n |=>
		!host_bus_grant_in) else $error("grant dropped early");
	a_yield_float_bus: assert property (!host_bus_grant_oe_n && !host_bus_grant_out |->
		bus_oe_n) else $error("bus driven under grant");
	a_suspend_float_bus: assert property ($fell(suspend_bus_float_n) |-> ##[1:5] bus_oe_n)
		else $error("bus not floated");
	a_ready_needs_sel: assert property ((chip_select_n || host_bus_request_n)[*6] |->
		host_wait_ready_oe_n) else $error("ready driven unselected");
	a_br_own_line: assert property ($countones(~br_oe_n) <= 1)
		else $error("several request lines driven");
	a_ready_wait_end: assert property ($fell(host_wait_ready_in) |->
		!host_wait_ready_in ##[1:3] host_wait_ready_in) else $error("ready wait too long");
endmodule : bus_arb_properties
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench: both ends joined through the link interface
// assumes pull-ups on every open-drain or released wire of the link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import bus_arb_pkg::*;
	logic       clk, rst_n, rds, ext_req, slave_acc, want, h_want, h_acc, h_susp, lo, hi, saw;
	logic [2:0] id;
	wire logic  x_done, master, owned, h_done;
	int         fail_count = 0;
	int         cmp_count = 0;
	int         i, k;
	// identity beside the request lines that it must drive (low enable = driven)
	logic [8:0] rows [7] = '{{3'h0, 6'h3f}, {3'h1, 6'h3e}, {3'h2, 6'h3d}, {3'h3, 6'h3b},
		{3'h4, 6'h37}, {3'h5, 6'h2f}, {3'h6, 6'h1f}};
	bus_arb_if link ();
	assign link.ack_in = link.ack_oe_n ? 1'b1 : link.ack_out;
	assign link.host_bus_grant_in = link.host_bus_grant_oe_n ? 1'b1 : link.host_bus_grant_out;
	assign link.host_wait_ready_in = link.host_wait_ready_oe_n ? 1'b1 : link.host_wait_ready_out;
	assign link.br_in = link.br_out | link.br_oe_n;
	bus_arb_dev #(.WAIT_CYCLES(2)) bus_arb_dev_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
		.PROCESSOR_IDENTITY_INPUTS_IN(id), .READY_DRIVE_SELECT_IN(rds),
		.EXT_ACCESS_REQ_IN(ext_req), .SYNC_SLAVE_ACCESS_IN(slave_acc), .WANT_BUS_IN(want),
		.EXT_ACCESS_DONE_OUT(x_done), .IS_MASTER_OUT(master), .link(link));
	bus_arb_host bus_arb_host_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .BUS_WANT_IN(h_want),
		.ACCESS_REQ_IN(h_acc), .SUSPEND_REQ_IN(h_susp), .BUS_OWNED_OUT(owned),
		.ACCESS_DONE_OUT(h_done), .link(link));
	bus_arb_properties bus_arb_properties_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
		.ack_out(link.ack_out), .ack_oe_n(link.ack_oe_n),
		.suspend_bus_float_n(link.suspend_bus_float_n),
		.host_bus_request_n(link.host_bus_request_n),
		.host_bus_grant_out(link.host_bus_grant_out),
		.host_bus_grant_oe_n(link.host_bus_grant_oe_n),
		.host_bus_grant_in(link.host_bus_grant_in), .chip_select_n(link.chip_select_n),
		.host_wait_ready_in(link.host_wait_ready_in),
		.host_wait_ready_oe_n(link.host_wait_ready_oe_n), .br_oe_n(link.br_oe_n),
		.bus_oe_n(link.bus_oe_n));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// a bounded wait that ran out ends the run at once
	task automatic need(input logic ok);
		check(ok, 1'b1);
		if (ok !== 1'b1)
			test_done();
	endtask : need
	task automatic do_reset(input logic [2:0] v);
		@(posedge clk) rst_n <= 1'b0;
		id <= v;
		repeat (6) @(posedge clk);
		@(negedge clk) check({link.bus_oe_n, link.host_bus_grant_oe_n}, 2'h3);
		@(posedge clk) rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : do_reset
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst_n, id, rds, ext_req, slave_acc, h_want, h_acc, h_susp} = '0;
		want = 1'b1;
		for (i = 0; i < 7; i++) begin
			do_reset(rows[i][8:6]);
			@(negedge clk) check(link.br_oe_n, rows[i][5:0]);
		end
		do_reset(ID_SINGLE);
		@(posedge clk) h_want <= 1'b1;
		for (i = 0; i < 30 && owned !== 1'b1; i++) @(negedge clk);
		need(owned);
		check({link.host_bus_grant_in, link.bus_oe_n}, 2'h1);
		// open-drain first, then active drive: only active drive may show a driven high
		for (k = 0; k < 2; k++) begin
			@(posedge clk) rds <= k[0];
			h_acc <= 1'b1;
			{lo, hi} = 2'b00;
			for (i = 0; i < 40 && h_done !== 1'b1; i++) begin
				@(negedge clk);
				lo |= !link.host_wait_ready_oe_n && !link.host_wait_ready_out;
				hi |= !link.host_wait_ready_oe_n && link.host_wait_ready_out;
			end
			need(h_done);
			check({lo, hi}, {1'b1, k[0]});
			@(posedge clk) h_acc <= 1'b0;
			repeat (8) @(posedge clk);
		end
		@(posedge clk) h_want <= 1'b0;
		repeat (10) @(negedge clk);
		check({link.host_bus_grant_in, owned}, 2'h2);
		@(posedge clk) h_susp <= 1'b1;
		// suspend must pass both ends' registers before the access starts
		repeat (6) @(posedge clk);
		ext_req <= 1'b1;
		saw = 1'b0;
		repeat (10) @(negedge clk) saw |= x_done;
		check({saw, link.bus_oe_n}, 2'h1);
		@(posedge clk) h_susp <= 1'b0;
		for (i = 0; i < 20 && x_done !== 1'b1; i++) @(negedge clk);
		need(x_done);
		@(posedge clk) ext_req <= 1'b0;
		slave_acc <= 1'b1;
		// inbound access only reaches a bus slave
		want <= 1'b0;
		for (i = 0; i < 8 && link.ack_oe_n !== 1'b0; i++) @(negedge clk);
		need(!link.ack_oe_n);
		@(posedge clk) slave_acc <= 1'b0;
		repeat (8) @(negedge clk);
		check(link.ack_oe_n, 1'b1);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
